// file: rtl/clk_div_pulse.sv
// Purpose: divides a source tick stream into system clock enable pulses
// Assumes: tick_i is a one-cycle pulse per source clock edge
// Notes:   restart_i realigns the count when the source changes
`timescale 1ns/1ps
module clk_div_pulse (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       restart_i,
    input  wire logic [7:0] ratio_i,
    output logic            pulse_o
);
    logic [8:0] cnt_ff;
    logic [8:0] last_count;
    logic       at_last;
    logic       pass_through;

    // ratio n divides by 2n, so count 0 .. 2n-1
    assign last_count   = {ratio_i, 1'b0} - 9'h001;
    assign at_last      = (cnt_ff >= last_count);
    assign pass_through = (ratio_i == 8'h00);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff  <= 9'h000;
            pulse_o <= 1'b0;
        end else if (restart_i) begin
            cnt_ff  <= 9'h000;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= tick_i & (pass_through | at_last);
            if (tick_i) begin
                cnt_ff <= (pass_through | at_last) ? 9'h000 : cnt_ff + 9'h001;
            end
        end
    end
endmodule

// file: rtl/clk_sel_defines.svh
// Purpose: offsets, field positions, reset values and counts of the clock select block
// Assumes: 8-bit register port, every register reachable on all pages
// Notes:   included by its bare name
`ifndef CLK_SEL_DEFINES_SVH
`define CLK_SEL_DEFINES_SVH

`define DIV_RATIO_ADDR     8'h95
`define SRC_SWITCH_ADDR    8'h96
`define SRC_ENABLE_ADDR    8'h97
`define TIMED_ACCESS_ADDR  8'hC7
`define IRQ_STATUS_ADDR    8'hC8
`define IRQ_MASK_ADDR      8'hC9

`define DIV_RATIO_RESET    8'h00
`define SRC_SWITCH_RESET   8'h30
`define SRC_ENABLE_RESET   8'h30
`define IRQ_MASK_RESET     2'h0

// source switch layout
`define SW_FAST_ST_BIT     5
`define SW_SLOW_ST_BIT     4
`define SW_EXT_ST_BIT      3
`define SW_SEL_HI          2
`define SW_SEL_LO          1

// source enable layout
`define EN_EXT_HI          7
`define EN_EXT_LO          6
`define EN_FAST_BIT        5
`define EN_RSVD_ONE_BIT    4
`define EN_FAULT_BIT       0

`define SRC_FAST           2'h0
`define SRC_EXT            2'h1
`define SRC_SLOW           2'h2
`define SRC_RESERVED       2'h3
`define EXT_ON_CODE        2'h3

// unlock sequence and length of the open window in clock cycles
`define TA_KEY_FIRST       8'hAA
`define TA_KEY_SECOND      8'h55
`define TA_OPEN_CYCLES     3'h4

`define IRQ_DONE_BIT       0
`define IRQ_FAULT_BIT      1

`endif

// file: rtl/clk_sel_pkg.sv
// Purpose: types shared by the clock select block
// Assumes: nothing beyond the defines header
// Notes:   numeric values live in clk_sel_defines.svh
package clk_sel_pkg;
    typedef logic [1:0] src_sel_t;
    typedef logic [7:0] sfr_byte_t;
    typedef enum logic [0:0] {SW_IDLE, SW_PENDING} sw_state_t;
    typedef enum logic [1:0] {TA_LOCKED, TA_HALF, TA_OPEN} ta_state_t;
endpackage

// file: rtl/system_clock_select_divider.sv
// Purpose: selects the system clock source, divides it, reports source status
// Assumes: oscillator edges arrive as one-cycle tick pulses synchronous to core_clk_i
// Notes:   system clock leaves as an enable pulse, never as a gated clock
// Operation
// - Divide ratio zero passes the source through, otherwise it divides by twice the ratio.
// - Select code 00 picks the fast oscillator, 01 the external input, 10 the slow oscillator.
// - The select field is write-only and its read-back need not show the source in use; the code reads back the last value written.
// - The fast oscillator status reads one only while that oscillator is enabled and stable, or while in-application programming is on.
// - The external status reads one only while the external input is enabled and stable.
// - The external input pin is taken as a clock only while its enable field is 11.
// - The fast oscillator enable bit turns that oscillator off at zero and on at one.
// - In-application programming forces the fast oscillator on and sets its enable and status.
// - Leaving in-application programming restores the earlier enable and status values.
// - The switch fault flag is zero after a good switch and one after a bad target.
// - A switch to an enabled but unstable source holds the fault flag until it is stable, then completes.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "clk_sel_defines.svh"
module system_clock_select_divider (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            addr_i,
    input  wire clk_sel_pkg::sfr_byte_t wr_data_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output clk_sel_pkg::sfr_byte_t     rd_data_o,
    input  wire logic                  fast_tick_i,
    input  wire logic                  slow_tick_i,
    input  wire logic                  ext_tick_i,
    input  wire logic                  fast_osc_stable_i,
    input  wire logic                  slow_osc_stable_i,
    input  wire logic                  ext_input_stable_i,
    input  wire logic                  in_app_program_on_i,
    output logic                       fast_osc_on_o,
    output logic                       ext_input_on_o,
    output logic                       sys_clk_en_o,
    output clk_sel_pkg::src_sel_t      active_src_o,
    output logic                       irq_o
);
    import clk_sel_pkg::*;

    // register state
    sfr_byte_t  sys_divide_ratio_ff;
    src_sel_t   sel_written_ff;
    logic [1:0] ext_input_enable_ff;
    logic       fast_osc_on_ff;
    logic       fast_saved_ff;
    logic       iap_seen_ff;

    // switch control state
    src_sel_t   active_src_ff;
    src_sel_t   pend_src_ff;
    sw_state_t  sw_state_ff;
    logic       switch_fault_flag_ff;
    // timed access, interrupt, read data and pin state
    ta_state_t  ta_state_ff;
    logic [2:0] ta_cnt_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    sfr_byte_t  rd_data_ff;
    logic       irq_ff;
    logic       fast_pin_ff;
    logic       ext_pin_ff;

    // next values
    src_sel_t   nxt_active_src;
    src_sel_t   nxt_pend_src;
    sw_state_t  nxt_sw_state;
    logic       nxt_fault;
    logic       switch_now;
    logic       done_evt;
    logic       fault_evt;
    ta_state_t  nxt_ta_state;
    logic [2:0] nxt_ta_cnt;
    logic [1:0] nxt_irq_stat;
    sfr_byte_t  nxt_rd_data;

    // register decode; no page select takes part
    logic wr_div;
    logic wr_sw;
    logic wr_en;
    logic wr_ta;
    logic wr_mask;
    logic rd_stat;
    logic ta_open;
    logic wr_sw_ok;
    logic wr_en_ok;

    assign wr_div   = wr_i & (addr_i == `DIV_RATIO_ADDR);
    assign wr_sw    = wr_i & (addr_i == `SRC_SWITCH_ADDR);
    assign wr_en    = wr_i & (addr_i == `SRC_ENABLE_ADDR);
    assign wr_ta    = wr_i & (addr_i == `TIMED_ACCESS_ADDR);
    assign wr_mask  = wr_i & (addr_i == `IRQ_MASK_ADDR);
    assign rd_stat  = rd_i & (addr_i == `IRQ_STATUS_ADDR);
    assign ta_open  = (ta_state_ff == TA_OPEN);
    // plain writes to protected registers are dropped
    assign wr_sw_ok = wr_sw & ta_open;
    assign wr_en_ok = wr_en & ta_open;


    // source availability
    logic iap_on;
    logic ext_on;
    logic fast_status;
    logic ext_status;
    logic slow_status;
    logic [3:0] src_enabled;
    logic [3:0] src_stable;
    src_sel_t   req_src;

    assign iap_on      = in_app_program_on_i;
    assign ext_on      = (ext_input_enable_ff == `EXT_ON_CODE);
    // programming reports the fast oscillator ready regardless
    assign fast_status = iap_on | (fast_osc_on_ff & fast_osc_stable_i);
    assign ext_status  = ext_on & ext_input_stable_i;
    assign slow_status = slow_osc_stable_i;

    assign src_enabled = {1'b0, 1'b1, ext_on, fast_osc_on_ff | iap_on};
    assign src_stable  = {1'b0, slow_status, ext_status, fast_status};
    assign req_src     = wr_data_i[`SW_SEL_HI:`SW_SEL_LO];

    // switch control
    always_comb begin
        nxt_active_src = active_src_ff;
        nxt_pend_src   = pend_src_ff;
        nxt_sw_state   = sw_state_ff;
        nxt_fault      = switch_fault_flag_ff;
        switch_now     = 1'b0;
        done_evt       = 1'b0;
        fault_evt      = 1'b0;
        // reserved code is ignored and leaves the current request alone
        if (wr_sw_ok && req_src != `SRC_RESERVED) begin
            if (src_stable[req_src]) begin
                nxt_active_src = req_src;
                nxt_sw_state   = SW_IDLE;
                nxt_fault      = 1'b0;
                switch_now     = (req_src != active_src_ff);
                done_evt       = 1'b1;
            end else if (src_enabled[req_src]) begin
                // old source keeps running until the target settles
                nxt_pend_src   = req_src;
                nxt_sw_state   = SW_PENDING;
                nxt_fault      = 1'b1;
                fault_evt      = 1'b1;
            end else begin
                nxt_sw_state   = SW_IDLE;
                nxt_fault      = 1'b1;
                fault_evt      = 1'b1;
            end
        end else begin
            case (sw_state_ff)
                SW_IDLE: begin
                    nxt_sw_state = SW_IDLE;
                end
                SW_PENDING: begin
                    if (src_stable[pend_src_ff]) begin
                        nxt_active_src = pend_src_ff;
                        nxt_sw_state   = SW_IDLE;
                        nxt_fault      = 1'b0;
                        switch_now     = (pend_src_ff != active_src_ff);
                        done_evt       = 1'b1;
                    end
                end
                default: begin
                    nxt_sw_state = SW_IDLE;
                end
            endcase
        end
    end

    // source in use, pending target and fault flag
    // the fault flag has no software clear, only the next switch
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_src_ff        <= `SRC_FAST;
            pend_src_ff          <= `SRC_FAST;
            sw_state_ff          <= SW_IDLE;
            switch_fault_flag_ff <= 1'b0;
        end else begin
            active_src_ff        <= nxt_active_src;
            pend_src_ff          <= nxt_pend_src;
            sw_state_ff          <= nxt_sw_state;
            switch_fault_flag_ff <= nxt_fault;
        end
    end

    // timed access: key pair, then a short window for one protected write
    always_comb begin
        nxt_ta_state = ta_state_ff;
        nxt_ta_cnt   = ta_cnt_ff;
        case (ta_state_ff)
            TA_LOCKED: begin
                if (wr_ta && wr_data_i == `TA_KEY_FIRST) begin
                    nxt_ta_state = TA_HALF;
                end
            end
            TA_HALF: begin
                // any write other than the second key breaks the sequence
                if (wr_ta && wr_data_i == `TA_KEY_SECOND) begin
                    nxt_ta_state = TA_OPEN;
                    nxt_ta_cnt   = `TA_OPEN_CYCLES;
                end else if (wr_i) begin
                    nxt_ta_state = TA_LOCKED;
                end
            end
            TA_OPEN: begin
                nxt_ta_cnt = ta_cnt_ff - 3'h1;
                if (wr_sw || wr_en || ta_cnt_ff == 3'h1) begin
                    nxt_ta_state = TA_LOCKED;
                end
            end
            default: begin
                nxt_ta_state = TA_LOCKED;
            end
        endcase
    end

    // count is reloaded by the second key, a stale value is harmless
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ta_state_ff <= TA_LOCKED;
            ta_cnt_ff   <= 3'h0;
        end else begin
            ta_state_ff <= nxt_ta_state;
            ta_cnt_ff   <= nxt_ta_cnt;
        end
    end

    // software-written configuration
    // ratio and mask take plain writes; only switch and enable
    // need the window, as they can stop the clock
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_divide_ratio_ff <= `DIV_RATIO_RESET;
            sel_written_ff      <= `SRC_FAST;
            ext_input_enable_ff <= 2'h0;
            irq_mask_ff         <= `IRQ_MASK_RESET;
        end else begin
            if (wr_div) begin
                sys_divide_ratio_ff <= wr_data_i;
            end
            if (wr_sw_ok) begin
                sel_written_ff <= req_src;
            end
            if (wr_en_ok) begin
                ext_input_enable_ff <= wr_data_i[`EN_EXT_HI:`EN_EXT_LO];
            end
            if (wr_mask) begin
                irq_mask_ff <= wr_data_i[1:0];
            end
        end
    end

    // fast oscillator enable with the programming override
    // writes during programming are dropped so the saved copy
    // is what comes back at exit
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fast_osc_on_ff <= 1'b1;
            fast_saved_ff  <= 1'b1;
            iap_seen_ff    <= 1'b0;
        end else begin
            iap_seen_ff <= iap_on;
            if (iap_on && !iap_seen_ff) begin
                fast_saved_ff  <= fast_osc_on_ff;
                fast_osc_on_ff <= 1'b1;
            end else if (!iap_on && iap_seen_ff) begin
                fast_osc_on_ff <= fast_saved_ff;
            end else if (wr_en_ok && !iap_on) begin
                fast_osc_on_ff <= wr_data_i[`EN_FAST_BIT];
            end
        end
    end

    // source clock selection and division
    logic src_tick;
    logic div_pulse;

    // external ticks count only while the pin is taken as a clock
    // reserved code never becomes active; zero keeps the divider idle
    assign src_tick = (active_src_ff == `SRC_FAST) ? fast_tick_i :
                      (active_src_ff == `SRC_EXT)  ? (ext_tick_i & ext_on) :
                      (active_src_ff == `SRC_SLOW) ? slow_tick_i : 1'b0;

    // divider restarts on a switch so no short period is produced
    clk_div_pulse u_div (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tick_i     (src_tick),
        .restart_i  (switch_now),
        .ratio_i    (sys_divide_ratio_ff),
        .pulse_o    (div_pulse)
    );

    // interrupt status: set wins over the clear done by a read
    assign nxt_irq_stat = (irq_stat_ff & {2{~rd_stat}}) | {fault_evt, done_evt};

    // read path
    sfr_byte_t sw_view;
    sfr_byte_t en_view;

    // select bits echo the last write, not the live source
    assign sw_view = {2'h0, fast_status, slow_status, ext_status, sel_written_ff, 1'b0};
    assign en_view = {ext_input_enable_ff, fast_osc_on_ff | iap_on, 1'b1, 3'h0,
                      switch_fault_flag_ff};

    // unmapped addresses read zero
    always_comb begin
        case (addr_i)
            `DIV_RATIO_ADDR:  nxt_rd_data = sys_divide_ratio_ff;
            `SRC_SWITCH_ADDR: nxt_rd_data = sw_view;
            `SRC_ENABLE_ADDR: nxt_rd_data = en_view;
            `IRQ_STATUS_ADDR: nxt_rd_data = {6'h00, irq_stat_ff};
            `IRQ_MASK_ADDR:   nxt_rd_data = {6'h00, irq_mask_ff};
            default:          nxt_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_ff  <= 8'h00;
            irq_stat_ff <= 2'h0;
            irq_ff      <= 1'b0;
            fast_pin_ff <= 1'b1;
            ext_pin_ff  <= 1'b0;
        end else begin
            rd_data_ff  <= rd_i ? nxt_rd_data : 8'h00;
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
            fast_pin_ff <= fast_osc_on_ff | iap_on;
            ext_pin_ff  <= ext_on;
        end
    end

    // ports are plain copies of flops
    assign rd_data_o      = rd_data_ff;
    assign irq_o          = irq_ff;
    assign fast_osc_on_o  = fast_pin_ff;
    assign ext_input_on_o = ext_pin_ff;
    assign sys_clk_en_o   = div_pulse;
    assign active_src_o   = active_src_ff;
endmodule

// file: test/clk_sel_checker.sv
// Purpose: port-level assertions for the clock select block
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
`include "clk_sel_defines.svh"
module clk_sel_checker (
    input wire logic                   core_clk_i,
    input wire logic                   rst_i,
    input wire logic [7:0]             addr_i,
    input wire clk_sel_pkg::sfr_byte_t wr_data_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire clk_sel_pkg::sfr_byte_t rd_data_o,
    input wire logic                   fast_tick_i,
    input wire logic                   slow_tick_i,
    input wire logic                   ext_tick_i,
    input wire logic                   fast_osc_stable_i,
    input wire logic                   slow_osc_stable_i,
    input wire logic                   ext_input_stable_i,
    input wire logic                   in_app_program_on_i,
    input wire logic                   fast_osc_on_o,
    input wire logic                   ext_input_on_o,
    input wire logic                   sys_clk_en_o,
    input wire clk_sel_pkg::src_sel_t  active_src_o,
    input wire logic                   irq_o
);
    import clk_sel_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic en_wr;
    logic fast_off_wr;
    assign en_wr       = wr_i && addr_i == `SRC_ENABLE_ADDR;
    assign fast_off_wr = en_wr && !wr_data_i[`EN_FAST_BIT];
    property p_rd_slot;
        rd_data_o != 8'h00 |-> $past(rd_i);
    endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("read data outside slot");
    property p_src_legal;
        $changed(active_src_o) |-> active_src_o != `SRC_RESERVED;
    endproperty
    a_src_legal: assert property (p_src_legal) else $error("reserved source used");
    property p_switch_stable;
        $changed(active_src_o) |->
            (active_src_o == `SRC_FAST && $past(fast_osc_stable_i || in_app_program_on_i)) ||
            (active_src_o == `SRC_EXT && $past(ext_input_stable_i)) ||
            (active_src_o == `SRC_SLOW && $past(slow_osc_stable_i));
    endproperty
    a_switch_stable: assert property (p_switch_stable) else $error("switch to unstable");
    property p_sys_tick;
        sys_clk_en_o |-> $past(fast_tick_i || slow_tick_i || ext_tick_i);
    endproperty
    a_sys_tick: assert property (p_sys_tick) else $error("clock pulse without tick");
    property p_ext_on;
        $changed(ext_input_on_o) |-> $past(en_wr) || $past(en_wr, 2);
    endproperty
    a_ext_on: assert property (p_ext_on) else $error("pin mode changed unasked");
    property p_fast_prog;
        in_app_program_on_i |=> fast_osc_on_o;
    endproperty
    a_fast_prog: assert property (p_fast_prog) else $error("fast osc off in program");
    property p_fast_off;
        $fell(fast_osc_on_o) |->
            $past(fast_off_wr) || $past(fast_off_wr, 2) ||
            $past(in_app_program_on_i, 2) || $past(in_app_program_on_i, 3);
    endproperty
    a_fast_off: assert property (p_fast_off) else $error("fast osc dropped unasked");
    property p_ext_status;
        rd_i && addr_i == `SRC_SWITCH_ADDR && !ext_input_stable_i |=> !rd_data_o[`SW_EXT_ST_BIT];
    endproperty
    a_ext_status: assert property (p_ext_status) else $error("ext status while unstable");
    c_ext_src: cover property (active_src_o == `SRC_EXT);
    c_irq: cover property ($rose(irq_o));
    c_prog: cover property ($rose(in_app_program_on_i));
endmodule
bind system_clock_select_divider clk_sel_checker i_clk_sel_checker (
    .core_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .fast_tick_i, .slow_tick_i, .ext_tick_i, .fast_osc_stable_i, .slow_osc_stable_i,
    .ext_input_stable_i, .in_app_program_on_i, .fast_osc_on_o, .ext_input_on_o,
    .sys_clk_en_o, .active_src_o, .irq_o
);

// file: test/osc_model.sv
// Purpose: oscillator and external clock pin model for the clock select block
// Assumes: every source edge is one core cycle tick
// Notes:   a source that is off is silent and unstable at once
`timescale 1ns/1ps
module osc_model (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic fast_on_i,
    input  wire logic ext_on_i,
    input  wire logic ext_ok_i,
    output logic      fast_tick_o,
    output logic      slow_tick_o,
    output logic      ext_tick_o,
    output logic      fast_stable_o,
    output logic      slow_stable_o,
    output logic      ext_stable_o
);
    logic [2:0] phase_ff;
    logic [1:0] warm_ff;
    logic [1:0] nxt_warm;
    // fast source needs a few cycles of warm-up before it reports stable
    assign nxt_warm = !fast_on_i ? 2'h0 : (warm_ff == 2'h3 ? warm_ff : warm_ff + 2'h1);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_ff <= 3'h0;
            warm_ff  <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 3'h1;
            warm_ff  <= nxt_warm;
        end
    end
    assign fast_tick_o   = fast_on_i && phase_ff[0];
    assign fast_stable_o = fast_on_i && warm_ff == 2'h3;
    assign slow_tick_o   = phase_ff == 3'h7;
    assign slow_stable_o = !rst_i;
    assign ext_tick_o    = ext_on_i && ext_ok_i && phase_ff[1:0] == 2'h1;
    assign ext_stable_o  = ext_on_i && ext_ok_i;
endmodule

// file: test/tb.sv
// Purpose: self-checking bench for the clock select block
// Assumes: register port with read data one cycle after the strobe
// Notes:   reads queue their expectation, a monitor compares them
`timescale 1ns/1ps
`include "clk_sel_defines.svh"
module tb;
    import clk_sel_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    sfr_byte_t   wr_data_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        in_app_program_on_i = 1'b0;
    logic        ext_ok = 1'b0;
    logic        fast_tick_i, slow_tick_i, ext_tick_i;
    logic        fast_osc_stable_i, slow_osc_stable_i, ext_input_stable_i;
    logic        fast_osc_on_o, ext_input_on_o, sys_clk_en_o, irq_o;
    sfr_byte_t   rd_data_o;
    src_sel_t    active_src_o;
    logic [15:0] exp_q[$];
    logic        rd_seen_ff = 1'b0;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    int          ratio;
    int          period;
    always #12.5 core_clk_i = ~core_clk_i;
    system_clock_select_divider i_system_clock_select_divider (
        .core_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
        .fast_tick_i, .slow_tick_i, .ext_tick_i, .fast_osc_stable_i, .slow_osc_stable_i,
        .ext_input_stable_i, .in_app_program_on_i, .fast_osc_on_o, .ext_input_on_o,
        .sys_clk_en_o, .active_src_o, .irq_o);
    osc_model i_osc_model (
        .core_clk_i, .rst_i, .fast_on_i(fast_osc_on_o), .ext_on_i(ext_input_on_o),
        .ext_ok_i(ext_ok), .fast_tick_o(fast_tick_i), .slow_tick_o(slow_tick_i),
        .ext_tick_o(ext_tick_i), .fast_stable_o(fast_osc_stable_i),
        .slow_stable_o(slow_osc_stable_i), .ext_stable_o(ext_input_stable_i));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e});
        bus(1'b0, a, 8'h00);
    endtask
    // key pair then the protected write, spaced well inside the open window
    task automatic unlock_wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, `TIMED_ACCESS_ADDR, `TA_KEY_FIRST);
        bus(1'b1, `TIMED_ACCESS_ADDR, `TA_KEY_SECOND);
        bus(1'b1, a, d);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic next_pulse(output int n);
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (sys_clk_en_o !== 1'b1 && n < 200);
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    always @(posedge core_clk_i) begin
        if (rd_seen_ff) begin
            chk({8'h00, rd_data_o & exp_q[0][15:8]}, {8'h00, exp_q[0][7:0]});
            void'(exp_q.pop_front());
        end
        rd_seen_ff <= rd_i;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        ratio = $urandom(32'h037F257E);
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        idle(6);
        rd(`DIV_RATIO_ADDR, 8'hFF, `DIV_RATIO_RESET);
        rd(`SRC_ENABLE_ADDR, 8'hFF, `SRC_ENABLE_RESET);
        rd(`SRC_SWITCH_ADDR, 8'h2E, 8'h20);
        rd(8'h50, 8'hFF, 8'h00);
        end_test("reset");
        for (int i = 0; i < 3; i++) begin
            ratio = (i == 0) ? 0 : 1 + $urandom % 8;
            bus(1'b1, `DIV_RATIO_ADDR, ratio[7:0]);
            rd(`DIV_RATIO_ADDR, 8'hFF, ratio[7:0]);
            next_pulse(period);
            next_pulse(period);
            next_pulse(period);
            chk(period[15:0], (ratio == 0) ? 16'h0002 : 16'(4 * ratio));
        end
        end_test("divider");
        bus(1'b1, `SRC_ENABLE_ADDR, 8'hC0);
        idle(3);
        chk({15'h0, ext_input_on_o}, 16'h0000);
        rd(`SRC_ENABLE_ADDR, 8'hE0, 8'h20);
        end_test("lock");
        bus(1'b1, `IRQ_MASK_ADDR, 8'h03);
        unlock_wr(`SRC_ENABLE_ADDR, 8'hF0);
        idle(4);
        chk({15'h0, ext_input_on_o}, 16'h0001);
        unlock_wr(`SRC_SWITCH_ADDR, 8'h02);
        idle(4);
        chk({14'h0, active_src_o}, 16'h0000);
        chk({15'h0, irq_o}, 16'h0001);
        rd(`SRC_ENABLE_ADDR, 8'h01, 8'h01);
        ext_ok <= 1'b1;
        idle(12);
        chk({14'h0, active_src_o}, 16'h0001);
        rd(`SRC_ENABLE_ADDR, 8'hE1, 8'hE0);
        rd(`SRC_SWITCH_ADDR, 8'h28, 8'h28);
        rd(`IRQ_STATUS_ADDR, 8'h03, 8'h03);
        idle(3);
        chk({15'h0, irq_o}, 16'h0000);
        end_test("pending switch");
        bus(1'b1, `IRQ_MASK_ADDR, 8'h00);
        unlock_wr(`SRC_SWITCH_ADDR, 8'h04);
        idle(3);
        chk({14'h0, active_src_o}, 16'h0002);
        chk({15'h0, irq_o}, 16'h0000);
        bus(1'b1, `IRQ_MASK_ADDR, 8'h01);
        idle(3);
        chk({15'h0, irq_o}, 16'h0001);
        rd(`IRQ_STATUS_ADDR, 8'h01, 8'h01);
        unlock_wr(`SRC_SWITCH_ADDR, 8'h06);
        idle(3);
        chk({14'h0, active_src_o}, 16'h0002);
        unlock_wr(`SRC_ENABLE_ADDR, 8'hD0);
        idle(4);
        chk({15'h0, fast_osc_on_o}, 16'h0000);
        rd(`SRC_SWITCH_ADDR, 8'h20, 8'h00);
        unlock_wr(`SRC_SWITCH_ADDR, 8'h00);
        idle(3);
        rd(`SRC_ENABLE_ADDR, 8'h01, 8'h01);
        chk({14'h0, active_src_o}, 16'h0002);
        end_test("sources");
        in_app_program_on_i <= 1'b1;
        idle(8);
        chk({15'h0, fast_osc_on_o}, 16'h0001);
        rd(`SRC_ENABLE_ADDR, 8'h20, 8'h20);
        rd(`SRC_SWITCH_ADDR, 8'h20, 8'h20);
        in_app_program_on_i <= 1'b0;
        idle(8);
        chk({15'h0, fast_osc_on_o}, 16'h0000);
        rd(`SRC_ENABLE_ADDR, 8'h20, 8'h00);
        rd(`SRC_SWITCH_ADDR, 8'h20, 8'h00);
        idle(3);
        end_test("programming");
        report_and_stop();
    end
endmodule
